// ### logic/fcrb_pkg.sv
// Constants, types and field layouts shared by the fault and configuration bank
// How it works
// - Summary flag bit 7 is high exactly while any other fault bit is set.
// - Diagnostic fault bits latch on their fault and hold until software clears.
// - Writing 1 clears a latched diagnostic bit; writing 0 leaves it alone.
// - A clear written while the fault is still present is ignored.
// - Status fault bits follow the live condition with no software action.
// - First fault register: bit 6 status, bits 5 to 0 diagnostic.
// - Second fault register layout; bit 3 is reserved and reads zero.
// - Soft-start and input protection register resets to 0xF0 with its fields.
// - Binning registers hold two gain nibbles each, reset 0x50 and 0xCF.
// - First fault-flag routing register resets to 0x1F, six route selections.
// - Second fault-flag routing register resets to 0x03.
// - Writing a bank index to 0x03 loads three config registers into 0x05-0x07; for bank 0x1F, 0x05 loads zero.
// - Writing 0x00 to 0x04 with a bank selected commits the three window registers to configuration; for bank 0x1F, 0x05 is not stored.
`default_nettype none
package fcrb_pkg;
  // ==========================================================
  // Direct register addresses
  localparam logic [4:0] ADDR_FAULT_A = 5'h00;
  localparam logic [4:0] ADDR_FAULT_B = 5'h01;
  localparam logic [4:0] ADDR_INDEX = 5'h03;
  localparam logic [4:0] ADDR_COMMIT = 5'h04;
  localparam logic [4:0] ADDR_WIN_X = 5'h05;
  localparam logic [4:0] ADDR_WIN_Y = 5'h06;
  localparam logic [4:0] ADDR_WIN_Z = 5'h07;

  // ==========================================================
  // Fault register field layout
  localparam int SUMMARY_BIT = 7;
  localparam logic [7:0] DIAG_A_MASK = 8'h3F;
  localparam logic [7:0] STATUS_A_MASK = 8'h40;
  localparam logic [7:0] DIAG_B_MASK = 8'hB4;
  localparam logic [7:0] STATUS_B_MASK = 8'h43;
  localparam int RESERVED_B_BIT = 3;
  localparam logic [7:0] FAULT_RESET = 8'h00;

  // ==========================================================
  // Indirect access
  localparam logic [7:0] BANK_FIRST = 8'h18;
  localparam logic [7:0] BANK_LAST = 8'h1F;
  localparam logic [7:0] COMMIT_KEY = 8'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam int WIN_COUNT = 3;
  localparam int CFG_COUNT = 23;

  typedef logic [CFG_COUNT-1:0][7:0] fcrb_cfg_t;

  // Configuration reset values, entry 22 first down to entry 0
  localparam fcrb_cfg_t CFG_RESET = {
    8'h03, 8'h1F, 8'h00, 8'h00, 8'h1F, 8'h1F, 8'h00, 8'h00,
    8'h00, 8'h13, 8'h01, 8'h02, 8'h05, 8'h07, 8'h00, 8'h03,
    8'h08, 8'h0E, 8'h26, 8'hCF, 8'h50, 8'hF0, 8'h08};

  // Indices of configuration entries with checked fields
  localparam int CFG_SOFTSTART = 1;
  localparam int CFG_BIN_A = 2;
  localparam int CFG_BIN_B = 3;
  localparam int CFG_ROUTE_A = 21;
  localparam int CFG_ROUTE_B = 22;

  // ==========================================================
  // Live fault conditions from the analog monitors
  typedef struct packed {
    logic drive_supply_low;
    logic output_over_voltage;
    logic output_under_voltage;
    logic output_over_current;
    logic open_load;
    logic single_led_short;
    logic string_short;
    logic input_over_voltage;
    logic input_under_voltage;
    logic high_beam_fault;
    logic frequency_set_fault;
    logic low_side_overcurrent;
    logic regulator_low;
    logic over_temperature;
  } fcrb_fault_s;

  // Register access request from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } fcrb_req_s;

  // Whole state of the bank
  typedef struct packed {
    logic [7:0] fault_a;
    logic [7:0] fault_b;
    logic [7:0] index;
    logic [WIN_COUNT-1:0][7:0] win;
    fcrb_cfg_t cfg;
    logic [7:0] rdata;
    logic rvalid;
  } fcrb_state_s;
endpackage
`default_nettype wire

// ### logic/fcrb_bank.sv
// Fault reporting and indirect configuration register bank
`timescale 1ns/1ps
`default_nettype none
module fcrb_bank (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Register access and live faults
  input wire fcrb_pkg::fcrb_req_s req_in,
  input wire fcrb_pkg::fcrb_fault_s fault_in,
  // Register contents
  output logic [7:0] fault_a_out,
  output logic [7:0] fault_b_out,
  output logic [7:0] index_out,
  output fcrb_pkg::fcrb_cfg_t cfg_out,
  // Read answer
  output logic [7:0] rdata_out,
  output logic rvalid_out
);

  // ==========================================================
  // Helpers

  // Live conditions in first fault register bit order
  function automatic logic [7:0] live_a(input fcrb_pkg::fcrb_fault_s f);
    live_a = {1'b0, f.drive_supply_low, f.output_over_voltage, f.output_under_voltage,
      f.output_over_current, f.open_load, f.single_led_short, f.string_short};
  endfunction

  // Live conditions in second fault register bit order, bit 3 unused
  function automatic logic [7:0] live_b(input fcrb_pkg::fcrb_fault_s f);
    live_b = {f.input_over_voltage, f.input_under_voltage, f.high_beam_fault,
      f.frequency_set_fault, 1'b0, f.low_side_overcurrent, f.regulator_low,
      f.over_temperature};
  endfunction

  // Index names one of the eight configuration banks
  function automatic logic bank_ok(input logic [7:0] idx);
    bank_ok = (idx >= fcrb_pkg::BANK_FIRST) && (idx <= fcrb_pkg::BANK_LAST);
  endfunction

  // Configuration entry behind window slot j (X holds the highest entry)
  function automatic int cfg_slot(input logic [7:0] idx, input int j);
    cfg_slot = 3 * int'(idx - fcrb_pkg::BANK_FIRST) + 2 - j;
  endfunction

  // Latched diagnostic update; a fault present this cycle beats a clear
  function automatic logic [7:0] latch_upd(input logic [7:0] cur, input logic [7:0] live,
                                           input logic [7:0] clr, input logic [7:0] dmask,
                                           input logic [7:0] smask);
    latch_upd = ((live | (cur & ~clr)) & dmask) | (live & smask);
  endfunction

  fcrb_pkg::fcrb_state_s st;
  fcrb_pkg::fcrb_state_s next_st;

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [7:0] clr_a;
    logic [7:0] clr_b;
    logic [7:0] upd_a;
    int k;
    clr_a = 8'h00;
    clr_b = 8'h00;
    upd_a = 8'h00;
    k = 0;
    next_st = st;
    next_st.rvalid = 1'b0;

    // Write-one clears only reach diagnostic positions
    if (req_in.wr && req_in.addr == fcrb_pkg::ADDR_FAULT_A) begin
      clr_a = req_in.wdata & fcrb_pkg::DIAG_A_MASK;
    end
    if (req_in.wr && req_in.addr == fcrb_pkg::ADDR_FAULT_B) begin
      clr_b = req_in.wdata & fcrb_pkg::DIAG_B_MASK;
    end

    // Diagnostic bits latch, status bits follow the live level
    upd_a = latch_upd(st.fault_a, live_a(fault_in), clr_a,
      fcrb_pkg::DIAG_A_MASK, fcrb_pkg::STATUS_A_MASK);
    next_st.fault_a[6:0] = upd_a[6:0];
    next_st.fault_b = latch_upd(st.fault_b, live_b(fault_in), clr_b,
      fcrb_pkg::DIAG_B_MASK, fcrb_pkg::STATUS_B_MASK);
    // Summary is derived from the new bits so it never lags them
    next_st.fault_a[fcrb_pkg::SUMMARY_BIT] =
      (|next_st.fault_a[6:0]) | (|next_st.fault_b);

    if (req_in.wr) begin
      case (req_in.addr)
        fcrb_pkg::ADDR_INDEX: begin
          next_st.index = req_in.wdata;
          // Load the window; slots with no entry read as zero
          for (int j = 0; j < fcrb_pkg::WIN_COUNT; j++) begin
            k = cfg_slot(req_in.wdata, j);
            if (bank_ok(req_in.wdata) && k < fcrb_pkg::CFG_COUNT) begin
              next_st.win[j] = st.cfg[k];
            end else begin
              next_st.win[j] = 8'h00;
            end
          end
        end
        fcrb_pkg::ADDR_COMMIT: begin
          // Only the documented key commits; anything else is ignored
          if (req_in.wdata == fcrb_pkg::COMMIT_KEY && bank_ok(st.index)) begin
            for (int j = 0; j < fcrb_pkg::WIN_COUNT; j++) begin
              k = cfg_slot(st.index, j);
              if (k < fcrb_pkg::CFG_COUNT) begin
                next_st.cfg[k] = st.win[j];
              end
            end
          end
        end
        fcrb_pkg::ADDR_WIN_X: next_st.win[0] = req_in.wdata;
        fcrb_pkg::ADDR_WIN_Y: next_st.win[1] = req_in.wdata;
        fcrb_pkg::ADDR_WIN_Z: next_st.win[2] = req_in.wdata;
        default: begin
        end
      endcase
    end

    // Read answer, one cycle after the request
    if (req_in.rd) begin
      next_st.rvalid = 1'b1;
      case (req_in.addr)
        fcrb_pkg::ADDR_FAULT_A: next_st.rdata = st.fault_a;
        fcrb_pkg::ADDR_FAULT_B: next_st.rdata = st.fault_b;
        fcrb_pkg::ADDR_INDEX: next_st.rdata = st.index;
        fcrb_pkg::ADDR_WIN_X: next_st.rdata = st.win[0];
        fcrb_pkg::ADDR_WIN_Y: next_st.rdata = st.win[1];
        fcrb_pkg::ADDR_WIN_Z: next_st.rdata = st.win[2];
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      st.fault_a <= fcrb_pkg::FAULT_RESET;
      st.fault_b <= fcrb_pkg::FAULT_RESET;
      st.index <= fcrb_pkg::INDEX_RESET;
      st.win <= '0;
      st.cfg <= fcrb_pkg::CFG_RESET;
      st.rdata <= 8'h00;
      st.rvalid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign fault_a_out = st.fault_a;
  assign fault_b_out = st.fault_b;
  assign index_out = st.index;
  assign cfg_out = st.cfg;
  assign rdata_out = st.rdata;
  assign rvalid_out = st.rvalid;

  // ==========================================================
  // Assertions
  // Every check runs on the system clock and rests while reset is held
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // ==========================================================
  // Request shapes

  // Write to the first fault register
  sequence wr_fault_a;
    req_in.wr && req_in.addr == fcrb_pkg::ADDR_FAULT_A;
  endsequence

  // Write to the second fault register
  sequence wr_fault_b;
    req_in.wr && req_in.addr == fcrb_pkg::ADDR_FAULT_B;
  endsequence

  // Index write that names a real configuration bank
  sequence index_load;
    req_in.wr && req_in.addr == fcrb_pkg::ADDR_INDEX && bank_ok(req_in.wdata);
  endsequence

  // Keyed commit while a real bank is selected
  sequence commit_write;
    req_in.wr && req_in.addr == fcrb_pkg::ADDR_COMMIT && req_in.wdata == fcrb_pkg::COMMIT_KEY
      && bank_ok(st.index);
  endsequence

  // String short seen on the live input
  sequence short_seen;
    fault_in.string_short;
  endsequence

  sequence short_gone_quiet;
    !fault_in.string_short && !req_in.wr;
  endsequence

  // Short comes, then goes in a cycle with no write to clear it
  sequence short_pulse;
    short_seen ##1 short_gone_quiet;
  endsequence

  // ==========================================================
  // Summary flag

  // Summary shares the flop word with the bits it covers, so it may never lag them
  a_summary_flag: assert property (
    st.fault_a[fcrb_pkg::SUMMARY_BIT] == ((|st.fault_a[6:0]) | (|st.fault_b)))
    else $error("summary flag disagrees with fault bits");

  // A write of ones must not drop the summary or status of a live fault
  a_summary_kept: assert property (
    (wr_fault_a and fault_in.drive_supply_low)
      |=> st.fault_a[fcrb_pkg::SUMMARY_BIT] && st.fault_a[6])
    else $error("write disturbed summary or status bit");

  // ==========================================================
  // Diagnostic latching

  // A live diagnostic fault shows one edge later, clear or no clear
  a_diag_set_a: assert property (
    fault_in.output_over_voltage |=> st.fault_a[5])
    else $error("output overvoltage bit not set");

  a_diag_set_open: assert property (
    fault_in.open_load |=> st.fault_a[2])
    else $error("open load bit not set");

  a_diag_set_b: assert property (
    fault_in.low_side_overcurrent |=> st.fault_b[2])
    else $error("low side overcurrent bit not set");

  // Once latched the bit outlives its fault
  a_diag_latch_hold: assert property (
    short_pulse |=> st.fault_a[0])
    else $error("diagnostic bit lost without a clear");

  // ==========================================================
  // Write-one-to-clear

  // A one clears a bit whose fault has gone
  a_w1c_clear: assert property (
    (wr_fault_a and (req_in.wdata[0] && !fault_in.string_short)) |=> !st.fault_a[0])
    else $error("write one did not clear diagnostic bit");

  a_w1c_clear_b: assert property (
    (wr_fault_b and (req_in.wdata[5] && !fault_in.high_beam_fault)) |=> !st.fault_b[5])
    else $error("write one did not clear high beam bit");

  // A zero in the written byte leaves a latched bit alone
  a_w0_keeps: assert property (
    (wr_fault_a and (!req_in.wdata[1] && st.fault_a[1])) |=> st.fault_a[1])
    else $error("write zero disturbed diagnostic bit");

  // The fault wins when it is still present in the clearing cycle
  a_clear_ignored: assert property (
    (wr_fault_b and fault_in.input_over_voltage) |=> st.fault_b[7])
    else $error("clear won over an active fault");

  // ==========================================================
  // Status bits

  // Status bits trail the live level by exactly one edge
  a_status_live: assert property (
    ##1 (st.fault_a[6] == $past(fault_in.drive_supply_low)
      && st.fault_b[0] == $past(fault_in.over_temperature)))
    else $error("status bit does not follow live fault");

  a_status_live_b: assert property (
    ##1 (st.fault_b[6] == $past(fault_in.input_under_voltage)
      && st.fault_b[1] == $past(fault_in.regulator_low)))
    else $error("second register status bit does not follow live fault");

  // A write of ones cannot knock down a status bit whose fault is live
  a_status_write: assert property (
    (wr_fault_b and fault_in.regulator_low) |=> st.fault_b[1])
    else $error("write disturbed a live status bit");

  // Reserved position never sets, whatever the host writes
  a_reserved_zero: assert property (!st.fault_b[fcrb_pkg::RESERVED_B_BIT])
    else $error("reserved fault bit set");

  // ==========================================================
  // Configuration bank

  // First edge after release still shows the reset table
  a_reset_values: assert property (
    $rose(rst_n_in) |-> (st.cfg[fcrb_pkg::CFG_SOFTSTART] == 8'hF0
      && st.cfg[fcrb_pkg::CFG_BIN_A] == 8'h50 && st.cfg[fcrb_pkg::CFG_BIN_B] == 8'hCF
      && st.cfg[fcrb_pkg::CFG_ROUTE_A] == 8'h1F && st.cfg[fcrb_pkg::CFG_ROUTE_B] == 8'h03))
    else $error("configuration reset value wrong");

  // Index write copies the selected bank into the window slots
  a_bank_load: assert property (
    index_load |=> st.win[2] == $past(st.cfg[cfg_slot(req_in.wdata, 2)]))
    else $error("window not loaded from selected bank");

  a_bank_load_y: assert property (
    index_load |=> st.win[1] == $past(st.cfg[cfg_slot(req_in.wdata, 1)]))
    else $error("middle window slot not loaded from selected bank");

  // The last bank has no entry behind slot X, so that slot loads as zero
  a_empty_slot: assert property (
    (req_in.wr && req_in.addr == fcrb_pkg::ADDR_INDEX && req_in.wdata == fcrb_pkg::BANK_LAST)
      |=> st.win[0] == 8'h00)
    else $error("empty window slot not zero");

  // A window write lands in its slot on the next edge
  a_window_write: assert property (
    (req_in.wr && req_in.addr == fcrb_pkg::ADDR_WIN_X) |=> st.win[0] == $past(req_in.wdata))
    else $error("window write lost");

  // The index moves only on a write to its own address
  a_index_hold: assert property (
    !(req_in.wr && req_in.addr == fcrb_pkg::ADDR_INDEX) |=> $stable(st.index))
    else $error("index changed without a write");

  // Commit copies the window into the selected entries
  a_commit_path: assert property (
    commit_write |=> st.cfg[cfg_slot(st.index, 1)] == $past(st.win[1]))
    else $error("commit did not store window");

  // Window edits stay private until the keyed commit
  a_cfg_hold: assert property (
    !(req_in.wr && req_in.addr == fcrb_pkg::ADDR_COMMIT && req_in.wdata == fcrb_pkg::COMMIT_KEY
      && bank_ok(st.index)) |=> $stable(st.cfg))
    else $error("configuration changed without a commit");

  // ==========================================================
  // Read answer

  // Valid follows every read by one edge and carries the value before the edge
  a_read_fault: assert property (
    (req_in.rd && req_in.addr == fcrb_pkg::ADDR_FAULT_A)
      |=> rvalid_out && rdata_out == $past(st.fault_a))
    else $error("fault register read answer wrong");

  a_read_window: assert property (
    (req_in.rd && req_in.addr == fcrb_pkg::ADDR_WIN_Y)
      |=> rvalid_out && rdata_out == $past(st.win[1]))
    else $error("window read answer wrong");

  // The index reads back so the host can see which bank it holds
  a_read_index: assert property (
    (req_in.rd && req_in.addr == fcrb_pkg::ADDR_INDEX)
      |=> rvalid_out && rdata_out == $past(st.index))
    else $error("index read answer wrong");

endmodule
`default_nettype wire

// ### sim/fcrb_host_model.sv
// Host model that issues register requests to the bank
`timescale 1ns/1ps
`default_nettype none
module fcrb_host_model (
  // Clock
  input wire logic clk_sys_in,
  // Read answer
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  // Request
  output fcrb_pkg::fcrb_req_s req_out
);
  initial req_out = '0;

  // ==========================================================
  // Bus cycle
  // Idle lines show inverted values so stale data never looks valid
  task automatic put(input logic w, input logic r, input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    req_out = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge clk_sys_in);
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One-cycle write; callers keep reserved fields at zero
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    put(1'b1, 1'b0, a, d);
  endtask

  // Read; answer is flagged from the taking edge on and sampled at the next falling edge
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
    put(1'b0, 1'b1, a, 8'h00);
    v = rvalid_in;
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// ### sim/fcrb_bank_tb.sv
// Self-checking testbench of the fault and configuration bank
`timescale 1ns/1ps
`default_nettype none
module fcrb_bank_tb;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  fcrb_pkg::fcrb_req_s req;
  fcrb_pkg::fcrb_fault_s flt = '0;
  fcrb_pkg::fcrb_cfg_t cfg;
  logic [7:0] fa;
  logic [7:0] fb;
  logic [7:0] idx;
  logic [7:0] rdat;
  logic rv;
  int err_total = 0;
  int checked = 0;

  // ==========================================================
  // Clock, design and host
  always #50 clk_sys_in = ~clk_sys_in;

  fcrb_bank uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(req),
    .fault_in(flt), .fault_a_out(fa), .fault_b_out(fb), .index_out(idx),
    .cfg_out(cfg), .rdata_out(rdat), .rvalid_out(rv));
  fcrb_host_model host (.clk_sys_in(clk_sys_in), .rdata_in(rdat), .rvalid_in(rv),
    .req_out(req));

  // ==========================================================
  // Comparison helpers
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Read must answer with valid set at the sampling edge and the expected byte
  task automatic rchk(input string n, input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    chk({n, " valid"}, 8'h01, {7'h00, v});
    chk(n, e, d);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog, sized far above the few hundred cycles the tests need
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    // Reset values
    chk("cfg1", 8'hF0, cfg[1]);
    chk("cfg2", 8'h50, cfg[2]);
    chk("cfg3", 8'hCF, cfg[3]);
    chk("cfg21", 8'h1F, cfg[21]);
    chk("cfg22", 8'h03, cfg[22]);
    rchk("fault a rst", fcrb_pkg::ADDR_FAULT_A, 8'h00);
    $display("test reset done");
    // Each fault alone: latch or follow, clear refused while active
    for (int i = 0; i < 14; i++) begin
      logic isa;
      logic st;
      logic [7:0] m;
      logic [4:0] a;
      logic [7:0] clr;
      isa = (i >= 7);
      st = (i == 13) || (i == 5) || (i == 1) || (i == 0);
      m = isa ? 8'h01 << (i - 7) : (i >= 3 ? 8'h01 << (i + 1) : 8'h01 << i);
      a = isa ? fcrb_pkg::ADDR_FAULT_A : fcrb_pkg::ADDR_FAULT_B;
      // Clear-all byte keeps the reserved bit 3 of the second register at zero
      clr = isa ? 8'hFF : 8'hF7;
      @(negedge clk_sys_in);
      flt = fcrb_pkg::fcrb_fault_s'(14'h0001 << i);
      host.wr(a, clr);
      rchk("fault a on", fcrb_pkg::ADDR_FAULT_A, (isa ? m : 8'h00) | 8'h80);
      rchk("fault b on", fcrb_pkg::ADDR_FAULT_B, isa ? 8'h00 : m);
      @(negedge clk_sys_in);
      flt = '0;
      host.wr(a, 8'h00);
      rchk("fault a off", fcrb_pkg::ADDR_FAULT_A,
        st ? 8'h00 : ((isa ? m : 8'h00) | 8'h80));
      rchk("fault b off", fcrb_pkg::ADDR_FAULT_B, (st || isa) ? 8'h00 : m);
      host.wr(a, clr);
      chk("fault a clr", 8'h00, fa);
      chk("fault b clr", 8'h00, fb);
    end
    $display("test faults done");
    // Indirect window load and commit
    host.wr(fcrb_pkg::ADDR_INDEX, 8'h18);
    chk("index", 8'h18, idx);
    rchk("win x", fcrb_pkg::ADDR_WIN_X, 8'h50);
    rchk("win y", fcrb_pkg::ADDR_WIN_Y, 8'hF0);
    rchk("win z", fcrb_pkg::ADDR_WIN_Z, 8'h08);
    host.wr(fcrb_pkg::ADDR_WIN_X, 8'hA5);
    chk("no commit yet", 8'h50, cfg[2]);
    host.wr(fcrb_pkg::ADDR_COMMIT, 8'h01);
    chk("bad key", 8'h50, cfg[2]);
    host.wr(fcrb_pkg::ADDR_COMMIT, 8'h00);
    chk("commit", 8'hA5, cfg[2]);
    rchk("index rd", fcrb_pkg::ADDR_INDEX, 8'h18);
    rchk("commit rd", fcrb_pkg::ADDR_COMMIT, 8'h00);
    host.wr(fcrb_pkg::ADDR_INDEX, 8'h1F);
    rchk("win y last", fcrb_pkg::ADDR_WIN_Y, 8'h03);
    rchk("win z last", fcrb_pkg::ADDR_WIN_Z, 8'h1F);
    rchk("win x last", fcrb_pkg::ADDR_WIN_X, 8'h00);
    // Index outside the configuration banks: empty window, commit refused
    host.wr(fcrb_pkg::ADDR_INDEX, 8'h08);
    rchk("win y outside", fcrb_pkg::ADDR_WIN_Y, 8'h00);
    host.wr(fcrb_pkg::ADDR_COMMIT, 8'h00);
    chk("no commit outside", 8'h03, cfg[22]);
    $display("test indirect done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
